// ===== hdl/power_mode_controller.sv
// Purpose: Global power mode controller with clock templates and boost control
// Assumes: 100 MHz pclk, APB slave with one wait-free access phase
// Notes:   Wake inputs arrive from other domains and are filtered
//
// Behaviour
// - Active mode follows active template bits
// - Disabled resources get clocks gated
// - Template writes apply immediately
// - Processor may disable itself; wake re-enables
// - Wake returns to active, processor on
// - Boot mode is active
// - Alternate active uses its own template
// - Sleep resume within 15 us
// - Hibernate retains state and holds pins
// - Only pin interrupt wakes hibernate
// - Hibernate resume under 100 us
// - Enabled interrupt or reset sources wake
// - Peripheral, supervisor, timewheel, pin interrupts
// - Timewheel raises periodic wakeups
// - Reset pin, watchdog, precise reset wake
// - Boost voltage 1.8 V in 100 mV steps
// - Boost modes active and standby
// - Boost active in active modes
// - Sleep standby forces periodic refresh wake
// - Hibernate boost only active or off
// - Separate template per active mode
// - Sleep gates all resources
//
// Implementation choices: the register offsets and register access over APB.
`include "power_mode_controller_regs.svh"
`timescale 1ns/1ps

module power_mode_controller #(
  parameter int unsigned HIB_RES_CYCLES = `PMC_HIB_RES_CYC  // Hibernate resume count
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   periph_irq,
  input  wire logic                   supervisor_irq,
  input  wire logic                   pin_irq,
  input  wire logic                   external_reset_pin_n,
  input  wire logic                   watchdog_reset_source,
  input  wire logic                   precise_voltage_reset,
  output logic [`PMC_TMPL_W-1:0]      clk_en,
  output logic                        cpu_en,
  output logic [1:0]                  chip_mode,
  output logic                        io_hold,
  output logic                        retain,
  output power_mode_pkg::boost_mode_e boost_mode,
  output logic [`PMC_VSEL_W-1:0]      boost_vsel
);

  // Register file
  logic [`PMC_TMPL_W-1:0] act_tmpl_reg;   // Active template
  logic [`PMC_TMPL_W-1:0] alt_tmpl_reg;   // Alternate active template
  logic [`PMC_WAKE_W-1:0] wake_en_reg;    // Wake source enables
  logic [`PMC_VSEL_W-1:0] vsel_reg;       // Boost voltage code
  logic                   boost_stby_reg; // Use standby while asleep
  logic                   boost_hib_reg;  // Keep boost active in hibernate
  logic [`PMC_TW_W-1:0]   tw_period_reg;  // Timewheel period
  logic                   cpu_off_reg;    // Processor switched itself off
  logic                   cpu_force_reg;  // Processor forced on after wake
  logic [1:0]             target_reg;     // Low-power mode being entered

  // State and counters
  power_mode_pkg::pmc_state_e state_reg;
  logic [15:0]            cnt_reg;        // Entry and resume counter
  logic [`PMC_TW_W-1:0]   tw_cnt_reg;     // Timewheel counter
  logic                   tw_tick;        // One-cycle timewheel pulse

  // Synchronisers and filter
  logic [5:0]             sync1_reg;
  logic [5:0]             sync2_reg;
  logic [5:0]             sync3_reg;
  logic [5:0]             filt_reg;       // Debounced level
  logic [5:0]             filt_d_reg;     // For edge detection
  power_mode_pkg::wake_src_s wake_raw;    // Rising edges plus tick
  power_mode_pkg::wake_src_s wake_hib;    // Sources allowed in hibernate
  logic                   wake_any;       // Wake in running or sleep states
  logic                   wake_hib_any;   // Wake in hibernate

  // APB decode
  logic                   apb_setup;
  logic                   apb_wr;
  logic                   apb_valid;
  logic [31:0]            rd_mux;

  // Synchronisers: three stages per input, external reset inverted first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
      sync3_reg <= 6'h00;
    end else begin
      sync1_reg <= {precise_voltage_reset, watchdog_reset_source,
                    ~external_reset_pin_n, pin_irq, supervisor_irq, periph_irq};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_reg   <= 6'h00;
      filt_d_reg <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          filt_reg[i] <= sync3_reg[i];
        end
      end
      filt_d_reg <= filt_reg;
    end
  end

  // Edge-based events so a held level cannot re-wake after every entry
  always_comb begin
    logic [5:0] rise;
    rise = filt_reg & ~filt_d_reg;
    wake_raw.periph_irq            = rise[0];
    wake_raw.supervisor_irq        = rise[1];
    wake_raw.pin_irq               = rise[2];
    wake_raw.external_reset        = rise[3];
    wake_raw.watchdog_reset_source = rise[4];
    wake_raw.precise_voltage_reset = rise[5];
    wake_raw.timewheel             = tw_tick;
    wake_hib                       = '0;
    wake_hib.pin_irq               = rise[2];
  end

  // Standby boost in sleep forces the timewheel on for refresh wakes
  assign wake_any = |(wake_raw & (wake_en_reg |
                    ((state_reg == power_mode_pkg::st_sleep && boost_stby_reg) ?
                     `PMC_WAKE_W'(4) : `PMC_WAKE_W'(0))));
  assign wake_hib_any = |(wake_hib & wake_en_reg);

  // Timewheel: stops in hibernate, where no clocks run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tw_cnt_reg <= '0;
    end else if (state_reg == power_mode_pkg::st_hib || tw_tick) begin
      tw_cnt_reg <= '0;
    end else begin
      tw_cnt_reg <= tw_cnt_reg + `PMC_TW_W'(1);
    end
  end
  assign tw_tick = (tw_period_reg != '0) && (tw_cnt_reg == tw_period_reg - `PMC_TW_W'(1));

  // APB strobes
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pready & pwrite;

  // Word decode of implemented offsets
  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      `PMC_MODE_OFF, `PMC_ACT_TMPL_OFF, `PMC_ALT_TMPL_OFF, `PMC_WAKE_EN_OFF,
      `PMC_STATUS_OFF, `PMC_BOOST_OFF, `PMC_TW_PERIOD_OFF, `PMC_CPU_OFF_OFF: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction
  assign apb_valid = addr_ok(paddr);

  // Maps the state onto the visible mode code
  function automatic logic [1:0] mode_of(input power_mode_pkg::pmc_state_e s,
                                         input logic [1:0] tgt);
    case (s)
      power_mode_pkg::st_alt:   mode_of = `PMC_MODE_ALT;
      power_mode_pkg::st_sleep: mode_of = `PMC_MODE_SLEEP;
      power_mode_pkg::st_hib:   mode_of = `PMC_MODE_HIB;
      power_mode_pkg::st_enter: mode_of = tgt;
      // Still resuming: the mode being left stays visible until active
      power_mode_pkg::st_resume: mode_of = tgt;
      default:                  mode_of = `PMC_MODE_ACTIVE;
    endcase
  endfunction

  // Read mux; status shows state, processor and boost
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `PMC_MODE_OFF:      rd_mux[1:0] = mode_of(state_reg, target_reg);
      `PMC_ACT_TMPL_OFF:  rd_mux[`PMC_TMPL_W-1:0] = act_tmpl_reg;
      `PMC_ALT_TMPL_OFF:  rd_mux[`PMC_TMPL_W-1:0] = alt_tmpl_reg;
      `PMC_WAKE_EN_OFF:   rd_mux[`PMC_WAKE_W-1:0] = wake_en_reg;
      `PMC_STATUS_OFF:    rd_mux[7:0] = {boost_mode, cpu_en, 2'h0, state_reg};
      `PMC_BOOST_OFF:     rd_mux[9:0] = {boost_hib_reg, boost_stby_reg, 2'h0, vsel_reg};
      `PMC_TW_PERIOD_OFF: rd_mux[`PMC_TW_W-1:0] = tw_period_reg;
      `PMC_CPU_OFF_OFF:   rd_mux[0] = cpu_off_reg;
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // APB answer: ready in the first access cycle, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (apb_setup) begin
      pready  <= 1'b1;
      pslverr <= ~apb_valid;
      prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Configuration registers; template writes act at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_tmpl_reg   <= `PMC_ACT_TMPL_RST;
      alt_tmpl_reg   <= `PMC_ALT_TMPL_RST;
      wake_en_reg    <= `PMC_WAKE_EN_RST;
      vsel_reg       <= `PMC_VSEL_RST;
      boost_stby_reg <= 1'b0;
      boost_hib_reg  <= 1'b0;
      tw_period_reg  <= `PMC_TW_RST;
    end else if (apb_wr) begin
      case (paddr)
        `PMC_ACT_TMPL_OFF:  act_tmpl_reg  <= pwdata[`PMC_TMPL_W-1:0];
        `PMC_ALT_TMPL_OFF:  alt_tmpl_reg  <= pwdata[`PMC_TMPL_W-1:0];
        `PMC_WAKE_EN_OFF:   wake_en_reg   <= pwdata[`PMC_WAKE_W-1:0];
        `PMC_TW_PERIOD_OFF: tw_period_reg <= pwdata[`PMC_TW_W-1:0];
        `PMC_BOOST_OFF: begin
          // Codes past 5.0 V clamp to the top step
          vsel_reg <= (pwdata[`PMC_VSEL_W-1:0] > `PMC_VSEL_MAX) ?
                      `PMC_VSEL_MAX : pwdata[`PMC_VSEL_W-1:0];
          boost_stby_reg <= pwdata[`PMC_BOOST_STBY_BIT];
          boost_hib_reg  <= pwdata[`PMC_BOOST_HIB_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Processor self-disable and forced enable; a wake beats a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_off_reg   <= 1'b0;
      cpu_force_reg <= 1'b0;
    end else if (wake_any || wake_hib_any) begin
      cpu_off_reg   <= 1'b0;
      cpu_force_reg <= 1'b1;
    end else if (apb_wr && paddr == `PMC_CPU_OFF_OFF) begin
      cpu_off_reg   <= pwdata[0];
      cpu_force_reg <= 1'b0;
    end else if (apb_wr && (paddr == `PMC_ACT_TMPL_OFF || paddr == `PMC_ALT_TMPL_OFF)) begin
      cpu_force_reg <= 1'b0;  // Firmware takes the processor bit back
    end
  end

  // Mode sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= power_mode_pkg::st_active;
      target_reg <= `PMC_MODE_ACTIVE;
      cnt_reg    <= 16'h0000;
    end else begin
      case (state_reg)
        power_mode_pkg::st_active, power_mode_pkg::st_alt: begin
          if (wake_any) begin
            state_reg <= power_mode_pkg::st_active;
          end else if (apb_wr && paddr == `PMC_MODE_OFF) begin
            case (pwdata[1:0])
              `PMC_MODE_ACTIVE: state_reg <= power_mode_pkg::st_active;
              `PMC_MODE_ALT:    state_reg <= power_mode_pkg::st_alt;
              default: begin
                state_reg  <= power_mode_pkg::st_enter;
                target_reg <= pwdata[1:0];
                cnt_reg    <= 16'(`PMC_ENTRY_CYC - 1);
              end
            endcase
          end
        end
        power_mode_pkg::st_enter: begin
          if (wake_any) begin
            state_reg <= power_mode_pkg::st_active;
          end else if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end else if (target_reg == `PMC_MODE_HIB) begin
            state_reg <= power_mode_pkg::st_hib;
          end else begin
            state_reg <= power_mode_pkg::st_sleep;
          end
        end
        power_mode_pkg::st_sleep: begin
          if (wake_any) begin
            state_reg <= power_mode_pkg::st_resume;
            cnt_reg   <= 16'(`PMC_SLEEP_RES_CYC - 1);
          end
        end
        power_mode_pkg::st_hib: begin
          if (wake_hib_any) begin
            state_reg <= power_mode_pkg::st_resume;
            cnt_reg   <= 16'(HIB_RES_CYCLES - 1);
          end
        end
        power_mode_pkg::st_resume: begin
          if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end else begin
            state_reg <= power_mode_pkg::st_active;
          end
        end
        default: state_reg <= power_mode_pkg::st_active;
      endcase
    end
  end

  // Clock gates, processor enable and retention outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en    <= `PMC_ACT_TMPL_RST;
      cpu_en    <= 1'b1;
      chip_mode <= `PMC_MODE_ACTIVE;
      io_hold   <= 1'b0;
      retain    <= 1'b0;
    end else begin
      chip_mode <= mode_of(state_reg, target_reg);
      io_hold   <= (state_reg == power_mode_pkg::st_hib);
      retain    <= (state_reg == power_mode_pkg::st_hib) ||
                   (state_reg == power_mode_pkg::st_sleep);
      case (state_reg)
        power_mode_pkg::st_active: begin
          clk_en <= act_tmpl_reg;
          cpu_en <= cpu_force_reg | (act_tmpl_reg[`PMC_TMPL_CPU_BIT] & ~cpu_off_reg);
        end
        power_mode_pkg::st_alt: begin
          clk_en <= alt_tmpl_reg;
          cpu_en <= cpu_force_reg | (alt_tmpl_reg[`PMC_TMPL_CPU_BIT] & ~cpu_off_reg);
        end
        default: begin
          clk_en <= '0;
          cpu_en <= 1'b0;
        end
      endcase
    end
  end

  // Boost mode follows the sequencer state; voltage follows the boost register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boost_mode <= power_mode_pkg::boost_active;
      boost_vsel <= `PMC_VSEL_RST;
    end else begin
      boost_vsel <= vsel_reg;
      case (state_reg)
        power_mode_pkg::st_sleep:
          boost_mode <= boost_stby_reg ? power_mode_pkg::boost_standby :
                        power_mode_pkg::boost_active;
        power_mode_pkg::st_hib:
          boost_mode <= boost_hib_reg ? power_mode_pkg::boost_active :
                        power_mode_pkg::boost_off;
        default: boost_mode <= power_mode_pkg::boost_active;
      endcase
    end
  end

  // Assertion helper: counts resume cycles after a sleep wake
  logic [15:0] res_len_reg;   // Cycles spent in resume so far
  logic        res_sleep_reg; // Current resume started from sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_len_reg   <= 16'h0000;
      res_sleep_reg <= 1'b0;
    end else if (state_reg == power_mode_pkg::st_sleep && wake_any) begin
      res_len_reg   <= 16'h0000;
      res_sleep_reg <= 1'b1;
    end else if (state_reg == power_mode_pkg::st_resume) begin
      res_len_reg   <= res_len_reg + 16'h0001;
    end else if (state_reg == power_mode_pkg::st_hib) begin
      res_sleep_reg <= 1'b0;
    end
  end

  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ACTIVE_TMPL: assert property (state_reg == power_mode_pkg::st_active |=>
    clk_en == $past(act_tmpl_reg)) else $error("active gates differ from template");
  AST_SLEEP_GATED: assert property ($past(state_reg) == power_mode_pkg::st_sleep
    |-> clk_en == '0 && !cpu_en) else $error("clocks running in sleep");
  AST_WAKE_CPU: assert property ((state_reg == power_mode_pkg::st_active && wake_any)
    |=> ##2 cpu_en) else $error("processor not enabled after wake");
  AST_ENTRY_ABORT: assert property ((state_reg == power_mode_pkg::st_enter && wake_any)
    |=> state_reg == power_mode_pkg::st_active) else $error("wake lost during entry");
  AST_HIB_ONLY_PIN: assert property ((state_reg == power_mode_pkg::st_hib && !wake_hib_any)
    |=> state_reg == power_mode_pkg::st_hib) else $error("hibernate left without pin");
  AST_SLEEP_RESUME: assert property ((state_reg == power_mode_pkg::st_sleep && wake_any)
    |=> state_reg == power_mode_pkg::st_resume) else $error("sleep wake did not resume");
  AST_SLEEP_RES_LEN: assert property ((state_reg == power_mode_pkg::st_resume &&
    res_sleep_reg) |-> res_len_reg < 16'(`PMC_SLEEP_RES_CYC))
    else $error("sleep resume too long");
  AST_SLEEP_RES_END: assert property ((state_reg == power_mode_pkg::st_active &&
    $past(state_reg) == power_mode_pkg::st_resume && res_sleep_reg) |->
    res_len_reg == 16'(`PMC_SLEEP_RES_CYC)) else $error("sleep resume length wrong");
  AST_BOOST_ACTIVE: assert property ((state_reg == power_mode_pkg::st_active ||
    state_reg == power_mode_pkg::st_alt) |=> boost_mode == power_mode_pkg::boost_active)
    else $error("boost not active in active mode");
  AST_HIB_HOLD: assert property (state_reg == power_mode_pkg::st_hib |=> io_hold && retain)
    else $error("pins not held in hibernate");
  AST_VSEL_RANGE: assert property (boost_vsel <= `PMC_VSEL_MAX)
    else $error("boost code beyond top step");
  AST_TW_PERIOD: assert property (tw_tick && $stable(tw_period_reg) &&
    state_reg != power_mode_pkg::st_hib |=> !tw_tick) else $error("timewheel ticks twice");

  COV_SLEEP_WAKE: cover property (state_reg == power_mode_pkg::st_resume ##1
    state_reg == power_mode_pkg::st_active);
  COV_HIB_ENTRY: cover property (state_reg == power_mode_pkg::st_hib);
  COV_ENTRY_ABORT: cover property (state_reg == power_mode_pkg::st_enter && wake_any);
  COV_ALT_MODE: cover property (state_reg == power_mode_pkg::st_alt);

endmodule // power_mode_controller

// ===== include/power_mode_controller_regs.svh
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: 32-bit APB data, byte addresses, one register per aligned word
// Notes:   Definitions only
`ifndef POWER_MODE_CONTROLLER_REGS_SVH
`define POWER_MODE_CONTROLLER_REGS_SVH

// Register byte offsets
`define PMC_MODE_OFF       8'h00
`define PMC_ACT_TMPL_OFF   8'h04
`define PMC_ALT_TMPL_OFF   8'h08
`define PMC_WAKE_EN_OFF    8'h0C
`define PMC_STATUS_OFF     8'h10
`define PMC_BOOST_OFF      8'h14
`define PMC_TW_PERIOD_OFF  8'h18
`define PMC_CPU_OFF_OFF    8'h1C

// Requested mode codes in the mode register
`define PMC_MODE_ACTIVE    2'h0
`define PMC_MODE_ALT       2'h1
`define PMC_MODE_SLEEP     2'h2
`define PMC_MODE_HIB       2'h3

// Template layout: bit 0 is the processor, bit 1 the flash
`define PMC_TMPL_W         16
`define PMC_TMPL_CPU_BIT   0
`define PMC_ACT_TMPL_RST   16'hFFFF
`define PMC_ALT_TMPL_RST   16'hFFFC

// Wake enable layout follows wake_src_s, 7 bits
`define PMC_WAKE_W         7
`define PMC_WAKE_EN_RST    7'h7F

// Boost register: [5:0] voltage code, [8] sleep standby, [9] run in hibernate
`define PMC_VSEL_W         6
`define PMC_VSEL_MAX       6'h20
`define PMC_VSEL_RST       6'h00
`define PMC_BOOST_STBY_BIT 8
`define PMC_BOOST_HIB_BIT  9
`define PMC_BOOST_BASE_MV  1800
`define PMC_BOOST_STEP_MV  100

// Timewheel period in clock cycles
`define PMC_TW_W           16
`define PMC_TW_RST         16'h03E8

// Timing: clock rate, resume times in microseconds, entry length
`define PMC_CLK_MHZ        100
`define PMC_SLEEP_RES_US   15
`define PMC_SLEEP_RES_CYC  (`PMC_SLEEP_RES_US * `PMC_CLK_MHZ)
`define PMC_HIB_RES_US     100
`define PMC_HIB_RES_CYC    (`PMC_HIB_RES_US * `PMC_CLK_MHZ - 1)
`define PMC_ENTRY_CYC      4

`endif

// ===== include/power_mode_pkg.sv
// Purpose: Types shared by the power mode controller and its bench
// Assumes: Constants live in power_mode_controller_regs.svh
// Notes:   No numbers here beyond widths of the types
package power_mode_pkg;

  // Controller states
  typedef enum logic [2:0] {
    st_active,
    st_alt,
    st_enter,
    st_sleep,
    st_hib,
    st_resume
  } pmc_state_e;

  // Boost converter operating mode
  typedef enum logic [1:0] {
    boost_off,
    boost_standby,
    boost_active
  } boost_mode_e;

  // Wakeup sources, high means event present
  typedef struct packed {
    logic precise_voltage_reset;
    logic watchdog_reset_source;
    logic external_reset;
    logic pin_irq;
    logic timewheel;
    logic supervisor_irq;
    logic periph_irq;
  } wake_src_s;

endpackage

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the power mode controller over APB
// Assumes: One access cycle per APB transfer, wake inputs filtered 4 edges
// Notes:   Short hibernate resume count keeps the run brief
`timescale 1ns/1ps

module tb_top;
  logic        pclk;      // 100 MHz clock
  logic        presetn;   // Async reset, active low
  logic        psel;      // APB select
  logic        penable;   // APB enable
  logic        pwrite;    // APB direction
  logic [7:0]  paddr;     // APB byte address
  logic [31:0] pwdata;    // APB write data
  logic [31:0] prdata;    // APB read data
  logic        pready;    // APB ready
  logic        pslverr;   // APB error
  logic [5:0]  w;         // Wake events, high means present
  logic [15:0] clk_en;    // Clock enables
  logic        cpu_en;    // Processor enable
  logic [1:0]  chip_mode; // Global mode
  logic        io_hold;   // Pin hold
  logic        retain;    // State retention
  logic [5:0]  boost_vsel; // Boost voltage code
  power_mode_pkg::boost_mode_e boost_mode; // Boost mode
  logic [31:0] q;         // Last read data
  logic        e;         // Last error flag
  int          n_fail;    // Mismatches
  int          n_checks;  // Comparisons

  // Short hibernate resume so the run stays brief
  power_mode_controller #(.HIB_RES_CYCLES(20)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_irq(w[0]),
    .supervisor_irq(w[1]), .pin_irq(w[2]), .external_reset_pin_n(~w[3]),
    .watchdog_reset_source(w[4]), .precise_voltage_reset(w[5]),
    .clk_en(clk_en), .cpu_en(cpu_en), .chip_mode(chip_mode),
    .io_hold(io_hold), .retain(retain), .boost_mode(boost_mode),
    .boost_vsel(boost_vsel)
  );

  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Verdict and end of run, reached from the sequence and every timeout
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compare one value; unknown never matches
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (i == 50) begin
      n_fail++;
      $display("BAD %0t no pready", $time);
      tally_and_finish();
    end
  endtask

  // Bounded wait for a mode; a timeout ends the run
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int i;
    for (i = 0; i < lim && chip_mode !== m; i++) @(posedge pclk);
    n_checks++;
    if (chip_mode !== m) begin
      n_fail++;
      $display("BAD %0t mode %h not reached", $time, m);
      tally_and_finish();
    end
  endtask

  // Wake event held long enough to pass the input filter
  task automatic pulse(input int k);
    @(posedge pclk); w[k] <= 1'b1;
    repeat (8) @(posedge pclk);
    w[k] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  // Main sequence
  initial begin
    n_fail = 0; n_checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; w = 6'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(chip_mode, 32'h0);
    chk(clk_en, 32'hFFFF);
    chk(boost_mode, power_mode_pkg::boost_active);
    apb(1'b1, 8'h18, 32'h0); // Timewheel off so sleep waits for our events
    apb(1'b1, 8'h04, 32'h00F0);
    repeat (2) @(posedge pclk);
    chk(clk_en, 32'h00F0);
    chk(cpu_en, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    wait_mode(2'h1, 10);
    chk(clk_en, 32'hFFFC);
    chk(boost_mode, power_mode_pkg::boost_active);
    apb(1'b1, 8'h04, 32'hFFFF);
    apb(1'b1, 8'h00, 32'h0);
    wait_mode(2'h0, 10);
    apb(1'b1, 8'h1C, 32'h1);
    repeat (2) @(posedge pclk);
    chk(cpu_en, 32'h0);
    // Only the peripheral interrupt may wake from here
    apb(1'b1, 8'h0C, 32'h1);
    apb(1'b1, 8'h00, 32'h2);
    wait_mode(2'h2, 20);
    repeat (6) @(posedge pclk);
    chk(clk_en, 32'h0);
    chk(retain, 32'h1);
    chk(boost_mode, power_mode_pkg::boost_active);
    pulse(4);
    repeat (20) @(posedge pclk);
    chk(chip_mode, 32'h2);
    pulse(0);
    repeat (1400) @(posedge pclk);
    chk(chip_mode === 2'h0, 32'h0);
    wait_mode(2'h0, 200);
    repeat (2) @(posedge pclk);
    chk(cpu_en, 32'h1);
    chk(clk_en, 32'hFFFF);
    apb(1'b1, 8'h0C, 32'h7F);
    apb(1'b1, 8'h14, 32'h3F);
    repeat (2) @(posedge pclk);
    chk(boost_vsel, 32'h20);
    // Hibernate: only the pin interrupt may end it
    apb(1'b1, 8'h00, 32'h3);
    wait_mode(2'h3, 20);
    repeat (6) @(posedge pclk);
    chk(io_hold, 32'h1);
    chk(boost_mode, power_mode_pkg::boost_off);
    pulse(0);
    pulse(4);
    pulse(3);
    repeat (30) @(posedge pclk);
    chk(chip_mode, 32'h3);
    pulse(2);
    wait_mode(2'h0, 60);
    repeat (2) @(posedge pclk);
    chk(io_hold, 32'h0);
    // Periodic timewheel wake out of sleep
    apb(1'b1, 8'h18, 32'd50);
    apb(1'b1, 8'h00, 32'h2);
    wait_mode(2'h2, 20);
    wait_mode(2'h0, 1700);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'hFFFF);
    apb(1'b0, 8'h40, 32'h0);
    chk({q[30:0], e}, 32'h1);
    tally_and_finish();
  end
endmodule // tb_top
